// >>> hdl/lpmfc_pkg.sv
// Shared constants, types and timing figures for the LIN mode and fail-safe control block.
package lpmfc_pkg;

    // Operating modes of the transceiver.
    typedef enum logic [1:0] {
        LPMFC_OFF,
        LPMFC_STANDBY,
        LPMFC_NORMAL,
        LPMFC_SLEEP
    } lpmfc_mode_t;

    // One receive event carried through the buffer.
    typedef struct packed {
        logic lvl;      // Bus level seen, high means recessive.
        logic self_drv; // High when our own transmitter was driving dominant.
    } lpmfc_rx_t;

    // Clock and timebase.
    localparam int CLK_PERIOD_NS = 5;
    localparam int TICK_NS       = 1000;
    localparam int TICK_DIV      = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Time limits in microseconds; the tick is one microsecond.
    localparam int MODE_SELECT_OPEN_US   = 5;
    localparam int MODE_SELECT_CLOSE_US  = 10;
    localparam int ENABLE_TO_TX_DELAY_US = 1;
    localparam int WAKE_DOMINANT_US      = 50;
    localparam int DOMINANT_TIMEOUT_US   = 20000;
    localparam int UNDERVOLTAGE_DET_US   = 10;

    // Tick counts derived from the times; least times round up.
    localparam int MSEL_OPEN_TICKS  = (MODE_SELECT_OPEN_US * 1000 + TICK_NS - 1) / TICK_NS;
    localparam int MSEL_CLOSE_TICKS = (MODE_SELECT_CLOSE_US * 1000) / TICK_NS;
    localparam int ENTX_TICKS       = (ENABLE_TO_TX_DELAY_US * 1000 + TICK_NS - 1) / TICK_NS;
    localparam int WAKE_TICKS       = (WAKE_DOMINANT_US * 1000 + TICK_NS - 1) / TICK_NS;
    localparam int DOMTO_TICKS      = (DOMINANT_TIMEOUT_US * 1000) / TICK_NS;
    localparam int UVD_TICKS        = (UNDERVOLTAGE_DET_US * 1000 + TICK_NS - 1) / TICK_NS;

    // Supported bus bit rates, as bit times in microseconds.
    localparam int BIT_US_SLOWEST = 417;
    localparam int BIT_US_FASTEST = 50;

    // Receive buffer shape.
    localparam int RX_FIFO_DEPTH = 16;

    // Pin synchroniser lane positions.
    localparam int PIN_EN      = 0;
    localparam int PIN_TXD     = 1;
    localparam int PIN_LIN     = 2;
    localparam int PIN_PON     = 3;
    localparam int PIN_POFF    = 4;
    localparam int PIN_UV      = 5;
    localparam int PIN_OT_TRIP = 6;
    localparam int PIN_OT_REL  = 7;
    localparam int PIN_COUNT   = 8;

    // Reset values of pins and flops; transmit and bus lanes start at their idle high
    // level, so no false edge reaches the timers or the receive buffer after reset.
    localparam logic [PIN_COUNT-1:0] PIN_RST = 8'h06;
    localparam logic                 RXD_IDLE = 1'h1;

endpackage

// >>> hdl/lpmfc_fifo.sv
// Synchronous FIFO with valid and ready on both sides for the receive path.
`timescale 1ns/1ps
module lpmfc_fifo #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 16
) (
    // Clock and reset.
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    // Filling side.
    input  wire logic             i_in_valid,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_in_ready,
    // Draining side.
    output logic                  o_out_valid,
    output logic [WIDTH-1:0]      o_out_data,
    input  wire logic             i_out_ready
);

    localparam int AW = $clog2(DEPTH);

    // Pointer arithmetic relies on a power-of-two depth.
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("FIFO depth must be a power of two, at least 2.");
    end

    logic [WIDTH-1:0] mem_r [DEPTH];  // Storage words.
    logic [AW:0]      wr_ptr_r;       // Write pointer with wrap bit.
    logic [AW:0]      rd_ptr_r;       // Read pointer with wrap bit.
    logic             push;           // Word accepted this cycle.
    logic             pop;            // Word delivered this cycle.

    assign o_in_ready  = (wr_ptr_r - rd_ptr_r) != (AW + 1)'(DEPTH);
    assign o_out_valid = wr_ptr_r != rd_ptr_r;
    assign o_out_data  = mem_r[rd_ptr_r[AW-1:0]];
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;

    // Storage is written without reset; the pointers guard every read.
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_r[wr_ptr_r[AW-1:0]] <= i_in_data;
        end
    end

    // Pointers advance on accepted transfers only.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
        end
    end

endmodule

// >>> hdl/lpmfc_top.sv
// Mode, wake-up and fail-safe control of a LIN transceiver with regulator.
`timescale 1ns/1ps
module lpmfc_top
    import lpmfc_pkg::*;
#(
    parameter int DOMTO_COUNT = DOMTO_TICKS,
    parameter int WAKE_COUNT  = WAKE_TICKS,
    parameter int UVD_COUNT   = UVD_TICKS,
    parameter int FIFO_DEPTH  = RX_FIFO_DEPTH
) (
    // Clock and reset.
    input  wire logic i_clk,
    input  wire logic i_rst,
    // Controller side pins.
    input  wire logic i_en,
    input  wire logic i_txd,
    output logic      o_rxd,
    output logic      o_reset_out_n,
    // Bus pin, open drain; output enable high pulls the bus dominant.
    input  wire logic i_lin,
    output logic      o_lin_o,
    output logic      o_lin_oe,
    // Analog comparator inputs.
    input  wire logic i_vbat_above_pon,
    input  wire logic i_vbat_below_poff,
    input  wire logic i_vcc_below_uvd,
    input  wire logic i_temp_above_trip,
    input  wire logic i_temp_below_release,
    // Status outputs.
    output logic      o_reg_en,
    output logic [1:0] o_mode
);

    ////////////////////////////////////////////////////////////////////////////////
    // Elaboration checks.

    localparam int TW = $clog2(DOMTO_COUNT + 2);   // Common timer width.
    localparam int DW = $clog2(TICK_DIV);          // Divider width.

    // The default time-out must outlast a whole bit at the slowest rate.
    if (DOMTO_TICKS <= BIT_US_SLOWEST) begin : g_bad_rate
        $error("Default time-out cannot serve the slowest bit rate.");
    end
    // All timers share one counter width sized by the time-out, so every limit must fit it.
    if (DOMTO_COUNT < 1 || WAKE_COUNT < 1 || UVD_COUNT < 1 || WAKE_COUNT >= (1 << TW)
        || UVD_COUNT >= (1 << TW) || MSEL_CLOSE_TICKS >= (1 << TW)) begin : g_bad_time
        $error("Timer counts do not fit the shared counter width.");
    end
    // Wake timing must be longer than half a bit at the fastest rate.
    if (WAKE_COUNT <= BIT_US_FASTEST / 2) begin : g_bad_wake
        $error("Wake dominant count too short for the fastest rate.");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.

    logic [PIN_COUNT-1:0] pin_raw;    // Asynchronous inputs gathered.
    logic [PIN_COUNT-1:0] sync1_r;    // First stage, read by second stage only.
    logic [PIN_COUNT-1:0] pin_s;      // Second stage, safe for logic.

    assign pin_raw = {i_temp_below_release, i_temp_above_trip, i_vcc_below_uvd,
                      i_vbat_below_poff, i_vbat_above_pon, i_lin, i_txd, i_en};

    // Every pin gets its own two-flop synchroniser.
    for (genvar g = 0; g < PIN_COUNT; g++) begin : g_sync
        always_ff @(posedge i_clk) begin
            if (i_rst) begin
                sync1_r[g] <= PIN_RST[g];
                pin_s[g]   <= PIN_RST[g];
            end else begin
                sync1_r[g] <= pin_raw[g];
                pin_s[g]   <= sync1_r[g];
            end
        end
    end

    logic en_s;     // Enable, synchronised.
    logic txd_s;    // Transmit data, synchronised.
    logic lin_s;    // Bus level, high is recessive.
    assign en_s  = pin_s[PIN_EN];
    assign txd_s = pin_s[PIN_TXD];
    assign lin_s = pin_s[PIN_LIN];

    logic en_d_r;   // Previous enable, for edge detection.
    logic txd_d_r;  // Previous transmit level.
    logic lin_d_r;  // Previous bus level.

    // Edge history of the synchronised pins.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            en_d_r  <= 1'h0;
            txd_d_r <= 1'h1;
            lin_d_r <= 1'h1;
        end else begin
            en_d_r  <= en_s;
            txd_d_r <= txd_s;
            lin_d_r <= lin_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Microsecond tick divider.

    logic [DW-1:0] div_r;   // Divider count.
    logic          tick_r;  // One-cycle pulse per microsecond.

    // All timers count ticks so their counters stay narrow.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            div_r  <= '0;
            tick_r <= 1'h0;
        end else begin
            tick_r <= div_r == DW'(TICK_DIV - 1);
            div_r  <= (div_r == DW'(TICK_DIV - 1)) ? '0 : div_r + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Mode state and mode select window.

    lpmfc_mode_t   mode_r;      // Current operating mode.
    lpmfc_mode_t   mode_nxt;    // Next operating mode.
    logic          msel_r;      // Enable fell in Normal; window pending.
    logic [TW-1:0] msel_cnt_r;  // Ticks since enable fell.
    logic          rst_ok;      // Reset output about to be high.
    logic          wake_evt;    // Completed remote wake-up this cycle.
    logic          uv_r;        // Undervoltage confirmed.
    logic          msel_close;  // Window closes this cycle.
    logic          in_window;   // Window currently open.

    assign in_window  = msel_r && msel_cnt_r >= TW'(MSEL_OPEN_TICKS);
    // Decide on the last tick before the close time, so the sample never lands outside the window.
    assign msel_close = in_window && tick_r && msel_cnt_r >= TW'(MSEL_CLOSE_TICKS - 1);

    // Window timer starts on the enable fall in Normal.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            msel_r     <= 1'h0;
            msel_cnt_r <= '0;
        end else if (mode_r != LPMFC_NORMAL || en_s) begin
            // Enable back high abandons the pending selection.
            msel_r     <= 1'h0;
            msel_cnt_r <= '0;
        end else if (en_d_r && !en_s) begin
            msel_r     <= 1'h1;
            msel_cnt_r <= '0;
        end else if (msel_r && tick_r) begin
            msel_cnt_r <= msel_cnt_r + 1'b1;
        end
    end

    // Next-mode decision; supply loss outranks everything.
    always_comb begin
        mode_nxt = mode_r;
        unique case (mode_r)
            LPMFC_OFF: begin
                if (pin_s[PIN_PON] && pin_s[PIN_OT_REL]) begin
                    mode_nxt = LPMFC_STANDBY;
                end
            end
            LPMFC_STANDBY: begin
                // Uses the registered reset output, as the next-mode reset would loop back here.
                if (en_s && o_reset_out_n && !uv_r) begin
                    mode_nxt = LPMFC_NORMAL;
                end
            end
            LPMFC_NORMAL: begin
                // The level seen at window close picks the target mode.
                if (msel_close && o_reset_out_n && !uv_r) begin
                    mode_nxt = txd_s ? LPMFC_STANDBY : LPMFC_SLEEP;
                end
            end
            LPMFC_SLEEP: begin
                if (en_s) begin
                    mode_nxt = LPMFC_NORMAL;
                end else if (wake_evt) begin
                    mode_nxt = LPMFC_STANDBY;
                end
            end
        endcase
        // Temperature is not watched in Sleep.
        if (pin_s[PIN_OT_TRIP] && (mode_r == LPMFC_NORMAL || mode_r == LPMFC_STANDBY)) begin
            mode_nxt = LPMFC_OFF;
        end
        if (pin_s[PIN_POFF]) begin
            mode_nxt = LPMFC_OFF;
        end
    end

    // Mode register.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            mode_r <= LPMFC_OFF;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Regulator undervoltage and reset output.

    logic [TW-1:0] uv_cnt_r;   // Ticks with regulator below detect level.

    // A dip must last the detect time before it counts.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            uv_cnt_r <= '0;
            uv_r     <= 1'h0;
        end else if (!pin_s[PIN_UV]) begin
            uv_cnt_r <= '0;
            uv_r     <= 1'h0;
        end else if (tick_r && !uv_r) begin
            uv_cnt_r <= uv_cnt_r + 1'b1;
            uv_r     <= uv_cnt_r >= TW'(UVD_COUNT - 1);
        end
    end

    // Reset is low with the regulator off or under voltage.
    assign rst_ok = (mode_nxt == LPMFC_NORMAL || mode_nxt == LPMFC_STANDBY) && !uv_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Transmit path: arming, dominant time-out and driver.

    logic          tx_arm_r;    // Recessive seen since entering Normal.
    logic [TW-1:0] dom_cnt_r;   // Ticks of transmit held low.
    logic          dom_to_r;    // Dominant time-out expired.
    logic          drive;       // Pull the bus dominant next cycle.

    // The driver arms only after a recessive transmit level.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            tx_arm_r <= 1'h0;
        end else if (mode_nxt != LPMFC_NORMAL || !en_s) begin
            tx_arm_r <= 1'h0;
        end else if (txd_s) begin
            tx_arm_r <= 1'h1;
        end
    end

    // Falling transmit starts the timer, rising clears it.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            dom_cnt_r <= '0;
            dom_to_r  <= 1'h0;
        end else if (txd_s) begin
            dom_cnt_r <= '0;
            dom_to_r  <= 1'h0;
        end else if (txd_d_r) begin
            dom_cnt_r <= '0;
        end else if (tick_r && !dom_to_r) begin
            dom_cnt_r <= dom_cnt_r + 1'b1;
            dom_to_r  <= dom_cnt_r >= TW'(DOMTO_COUNT - 1);
        end
    end

    // Enable low cuts the driver in the same cycle it is seen.
    assign drive = mode_nxt == LPMFC_NORMAL && en_s && rst_ok && tx_arm_r
                   && !txd_s && !dom_to_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Remote wake-up detection.

    logic          wake_meas;     // Measurement allowed in this mode.
    logic          wake_low_r;    // Bus fell and is being timed.
    logic [TW-1:0] wake_cnt_r;    // Ticks of bus low.
    logic          wake_long_r;   // Low lasted long enough.
    logic          wake_pend_r;   // Wake request awaiting the controller.

    // During a pending selection the transmitter is off, so a late
    // transmit fall must not stop the timing.
    assign wake_meas = mode_r == LPMFC_SLEEP || mode_r == LPMFC_STANDBY
                       || (mode_r == LPMFC_NORMAL && (txd_s || msel_r));

    // Fall, long low, rise: only then is a wake reported.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wake_low_r  <= 1'h0;
            wake_cnt_r  <= '0;
            wake_long_r <= 1'h0;
        end else if (!wake_meas || lin_s) begin
            wake_low_r  <= 1'h0;
            wake_cnt_r  <= '0;
            wake_long_r <= 1'h0;
        end else if (lin_d_r) begin
            wake_low_r <= 1'h1;
        end else if (wake_low_r && tick_r && !wake_long_r) begin
            wake_cnt_r  <= wake_cnt_r + 1'b1;
            wake_long_r <= wake_cnt_r >= TW'(WAKE_COUNT - 1);
        end
    end

    assign wake_evt = wake_meas && wake_long_r && lin_s && !lin_d_r;

    // A new wake wins over the clear on entering Normal.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wake_pend_r <= 1'h0;
        end else if (wake_evt && mode_r != LPMFC_NORMAL) begin
            wake_pend_r <= 1'h1;
        end else if (mode_nxt == LPMFC_NORMAL || mode_nxt == LPMFC_OFF) begin
            wake_pend_r <= 1'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Receive buffer.

    lpmfc_rx_t rx_in;        // Event offered to the buffer.
    lpmfc_rx_t rx_out;       // Event at the buffer head.
    logic      rx_in_rdy;    // Buffer can take an event.
    logic      rx_out_vld;   // Buffer holds an event.
    logic      rx_pop;       // Head consumed.
    logic      rx_lvl_r;     // Last bus level accepted by the buffer.
    logic      hold_wake;    // Standby wake indication stalls the drain.

    assign rx_in.lvl      = lin_s;
    assign rx_in.self_drv = o_lin_oe;
    assign hold_wake      = mode_r == LPMFC_STANDBY && wake_pend_r;
    assign rx_pop         = !hold_wake;

    // A level change is retried until the buffer accepts it.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rx_lvl_r <= RXD_IDLE;
        end else if (rx_in_rdy) begin
            rx_lvl_r <= lin_s;
        end
    end

    lpmfc_fifo #(
        .WIDTH ($bits(lpmfc_rx_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_rx_fifo (
        .i_clk       (i_clk),
        .i_rst       (i_rst),
        .i_in_valid  (lin_s != rx_lvl_r),
        .i_in_data   (rx_in),
        .o_in_ready  (rx_in_rdy),
        .o_out_valid (rx_out_vld),
        .o_out_data  (rx_out),
        .i_out_ready (rx_pop)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Registered outputs.

    logic rxd_r;   // Receive output level.

    // Normal relays the bus; Standby shows a pending wake as low.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rxd_r <= RXD_IDLE;
        end else if (mode_r == LPMFC_STANDBY) begin
            rxd_r <= !wake_pend_r;
        end else if (mode_r != LPMFC_NORMAL) begin
            rxd_r <= RXD_IDLE;
        end else if (rx_out_vld) begin
            rxd_r <= rx_out.lvl;
        end
    end

    // Pin and status flops; the driven bus value is always dominant.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_lin_oe      <= 1'h0;
            o_lin_o       <= 1'h0;
            o_reset_out_n <= 1'h0;
            o_reg_en      <= 1'h0;
            o_mode        <= LPMFC_OFF;
        end else begin
            o_lin_oe      <= drive;
            o_lin_o       <= 1'h0;
            o_reset_out_n <= rst_ok;
            o_reg_en      <= mode_nxt == LPMFC_NORMAL || mode_nxt == LPMFC_STANDBY;
            o_mode        <= mode_nxt;
        end
    end

    assign o_rxd = rxd_r;

endmodule

// >>> verif/lpmfc_props.sv
// Port checker for the LIN mode and fail-safe control block.
`timescale 1ns/1ps
module lpmfc_props
    import lpmfc_pkg::*;
#(
    parameter int DOMTO_COUNT = DOMTO_TICKS,
    parameter int UVD_COUNT   = UVD_TICKS
) (
    // Clock and reset.
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    // Watched pins.
    input  wire logic       i_en,
    input  wire logic       i_txd,
    input  wire logic       o_rxd,
    input  wire logic       o_reset_out_n,
    input  wire logic       o_lin_oe,
    input  wire logic       i_vbat_below_poff,
    input  wire logic       i_vcc_below_uvd,
    input  wire logic       i_temp_above_trip,
    input  wire logic       o_reg_en,
    input  wire logic [1:0] o_mode
);
    // Limits allow one tick of quantisation plus the synchroniser delay.
    localparam int UV_LIM = (UVD_COUNT + 1) * TICK_DIV + 8;
    localparam int TO_LIM = (DOMTO_COUNT + 1) * TICK_DIV + 8;
    int uv_cnt_r; // Cycles of undervoltage in a row.
    int lo_cnt_r; // Cycles of transmit low in a row.
    ////////////////////////////////////////////////////////////////////////
    // Run lengths saturate just past the limit so they never wrap.
    always_ff @(posedge i_clk) begin
        if (i_rst || !i_vcc_below_uvd) uv_cnt_r <= 0;
        else if (uv_cnt_r <= UV_LIM) uv_cnt_r <= uv_cnt_r + 1;
    end
    // Transmit low run, cleared by any high level.
    always_ff @(posedge i_clk) begin
        if (i_rst || i_txd) lo_cnt_r <= 0;
        else if (lo_cnt_r <= TO_LIM) lo_cnt_r <= lo_cnt_r + 1;
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    chk_oe_enable_low: assert property ((!i_en) [*4] |=> !o_lin_oe)
        else $error("Transmitter on with enable low.");
    chk_oe_txd_high: assert property (i_txd [*4] |=> !o_lin_oe)
        else $error("Bus dominant with transmit high.");
    chk_sleep_outputs: assert property (o_mode == LPMFC_SLEEP |-> !o_reg_en && !o_reset_out_n)
        else $error("Sleep with regulator or reset up.");
    chk_off_outputs: assert property (o_mode == LPMFC_OFF |-> !(o_reg_en || o_reset_out_n || o_lin_oe))
        else $error("Off mode with outputs active.");
    chk_poff_to_off: assert property (i_vbat_below_poff [*4] |=> o_mode == LPMFC_OFF)
        else $error("Battery loss did not force Off.");
    chk_hot_to_off: assert property (
        (i_temp_above_trip && o_mode != LPMFC_SLEEP) [*4] |=> o_mode == LPMFC_OFF)
        else $error("Overtemperature did not force Off.");
    chk_wake_rxd_low: assert property ($past(o_mode) == LPMFC_SLEEP && o_mode == LPMFC_STANDBY |=> !o_rxd)
        else $error("Wake not shown on receive.");
    chk_uv_reset_low: assert property (uv_cnt_r > UV_LIM |-> !o_reset_out_n)
        else $error("Undervoltage did not pull reset.");
    chk_dom_timeout: assert property (lo_cnt_r > TO_LIM |-> !o_lin_oe)
        else $error("Dominant time-out missed.");
    chk_enter_normal: assert property ($rose(i_en) && o_mode == LPMFC_STANDBY && o_reset_out_n
        && !i_vcc_below_uvd |-> ##[1:6] o_mode == LPMFC_NORMAL)
        else $error("Enable did not enter Normal.");
endmodule
bind lpmfc_top lpmfc_props #(.DOMTO_COUNT(DOMTO_COUNT), .UVD_COUNT(UVD_COUNT)) u_props (
    .i_clk(i_clk), .i_rst(i_rst), .i_en(i_en), .i_txd(i_txd), .o_rxd(o_rxd),
    .o_reset_out_n(o_reset_out_n), .o_lin_oe(o_lin_oe), .i_vbat_below_poff(i_vbat_below_poff),
    .i_vcc_below_uvd(i_vcc_below_uvd), .i_temp_above_trip(i_temp_above_trip),
    .o_reg_en(o_reg_en), .o_mode(o_mode));

// >>> verif/lpmfc_ctrl_model.sv
// Protocol controller model driving the enable and transmit pins.
`timescale 1ns/1ps
module lpmfc_ctrl_model (
    // Clock.
    input  wire logic       i_clk,
    // Wanted mode: 1 Normal, 2 Standby, 3 Sleep, 0 idle.
    input  wire logic [1:0] i_cmd,
    input  wire logic       i_bit,
    // Pins towards the transceiver.
    output logic            o_en,
    output logic            o_txd
);
    logic [1:0] cmd_r = 2'h0; // Registered wish.
    logic       bit_r = 1'h1; // Registered data bit.
    // Both pins decode the same wish register, so enable and transmit fall together.
    always_ff @(posedge i_clk) begin
        cmd_r <= i_cmd;
        bit_r <= i_bit;
    end
    assign o_en = (cmd_r == 2'h1);
    // The select level is held for as long as the wish stands.
    assign o_txd = (cmd_r == 2'h1) ? bit_r : (cmd_r != 2'h3);
endmodule

// >>> verif/tb_lpmfc_top.sv
// Self-checking bench for the LIN mode and fail-safe control block.
`timescale 1ns/1ps
module tb_lpmfc_top
    import lpmfc_pkg::*;
;
    localparam int DOMTO = 20; // Shortened time-out in ticks.
    localparam int WAKE  = 30; // Shortened wake time in ticks.
    localparam int UVD   = 10;
    logic       i_clk = 1'h0, i_rst = 1'h1;
    logic       pon = 1'h0, poff = 1'h1, rel = 1'h1, trip = 1'h0, uv = 1'h0;
    logic       bus_drv = 1'h1, tx_bit = 1'h1; // Far node drive, data bit.
    logic [1:0] cmd = 2'h0;
    logic       en, txd, rxd, rst_n, lin_o, lin_oe, reg_en, lin_w;
    logic [1:0] mode;
    int         failures = 0, n_compared = 0;
    // Open drain bus with pull-up; any dominant driver wins.
    assign lin_w = (lin_oe ? lin_o : 1'h1) & bus_drv;
    initial forever #2.5 i_clk = ~i_clk;
    lpmfc_ctrl_model u_ctrl (.i_clk(i_clk), .i_cmd(cmd), .i_bit(tx_bit), .o_en(en), .o_txd(txd));
    lpmfc_top #(.DOMTO_COUNT(DOMTO), .WAKE_COUNT(WAKE), .UVD_COUNT(UVD)) DUT (
        .i_clk(i_clk), .i_rst(i_rst), .i_en(en), .i_txd(txd), .o_rxd(rxd), .o_reset_out_n(rst_n),
        .i_lin(lin_w), .o_lin_o(lin_o), .o_lin_oe(lin_oe), .i_vbat_above_pon(pon),
        .i_vbat_below_poff(poff), .i_vcc_below_uvd(uv), .i_temp_above_trip(trip),
        .i_temp_below_release(rel), .o_reg_en(reg_en), .o_mode(mode));
    ////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        if (failures == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Sampling sits just after the edge so updates have landed.
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic chk(input logic [1:0] seen, input logic [1:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // A wait that runs out is counted and ends the run.
    task automatic wait_mode(input logic [1:0] m, input int lim);
        for (int i = 0; i < lim && mode !== m; i++) cyc(1);
        chk(mode, m);
        if (mode !== m) summarize();
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic s_power();
        cyc(8);
        chk({reg_en, rst_n}, 2'h0);
        @(posedge i_clk); pon <= 1'h1; poff <= 1'h0; rel <= 1'h0;
        cyc(20); chk(mode, LPMFC_OFF);
        @(posedge i_clk); rel <= 1'h1;
        wait_mode(LPMFC_STANDBY, 20);
        cyc(2); chk({reg_en, rst_n}, 2'h3);
    endtask
    // Entering Normal with transmit low must not drive until a high is seen.
    task automatic s_normal();
        @(posedge i_clk); cmd <= 2'h1; tx_bit <= 1'h0;
        wait_mode(LPMFC_NORMAL, 20);
        cyc(20); chk({lin_oe, rxd}, 2'h1);
        @(posedge i_clk); tx_bit <= 1'h1;
        cyc(8); chk({lin_oe, rxd}, 2'h1);
        @(posedge i_clk); tx_bit <= 1'h0;
        cyc(8); chk({lin_oe, rxd}, 2'h2);
        @(posedge i_clk); tx_bit <= 1'h1; bus_drv <= 1'h0;
        cyc(8); chk({lin_oe, rxd}, 2'h0);
        @(posedge i_clk); bus_drv <= 1'h1;
    endtask
    task automatic s_timeout();
        @(posedge i_clk); tx_bit <= 1'h0;
        cyc(8); chk({lin_oe, rxd}, 2'h2);
        cyc((DOMTO + 2) * TICK_DIV); chk({lin_oe, rxd}, 2'h1);
        @(posedge i_clk); tx_bit <= 1'h1;
        cyc(4);
        @(posedge i_clk); tx_bit <= 1'h0;
        cyc(8); chk({lin_oe, rxd}, 2'h2);
        @(posedge i_clk); tx_bit <= 1'h1;
    endtask
    task automatic s_standby();
        @(posedge i_clk); cmd <= 2'h2;
        cyc(800); chk(mode, LPMFC_NORMAL);
        wait_mode(LPMFC_STANDBY, 1400);
        chk({lin_oe, rxd}, 2'h1);
    endtask
    // Bit b high makes transmit fall with enable; bit b low holds transmit low, so the driver never arms.
    task automatic s_sleep(input logic b);
        @(posedge i_clk); cmd <= 2'h1; tx_bit <= b;
        wait_mode(LPMFC_NORMAL, 20);
        cyc(8);
        @(posedge i_clk); cmd <= 2'h3;
        cyc(6);
        repeat (4) begin
            chk({lin_oe, rxd}, 2'h1);
            cyc(1);
        end
        wait_mode(LPMFC_SLEEP, 2500);
        chk({reg_en, rst_n}, 2'h0);
    endtask
    task automatic s_wake();
        @(posedge i_clk); bus_drv <= 1'h0;
        cyc(WAKE * TICK_DIV / 2);
        @(posedge i_clk); bus_drv <= 1'h1;
        cyc(20); chk(mode, LPMFC_SLEEP);
        @(posedge i_clk); bus_drv <= 1'h0;
        cyc((WAKE + 2) * TICK_DIV); chk(mode, LPMFC_SLEEP);
        @(posedge i_clk); bus_drv <= 1'h1;
        wait_mode(LPMFC_STANDBY, 20);
        cyc(100); chk({reg_en, rxd}, 2'h2);
        @(posedge i_clk); cmd <= 2'h1;
        wait_mode(LPMFC_NORMAL, 20);
        cyc(8); chk({lin_oe, rxd}, 2'h1);
    endtask
    task automatic s_uv_temp();
        @(posedge i_clk); tx_bit <= 1'h0; uv <= 1'h1;
        cyc((UVD - 2) * TICK_DIV); chk({lin_oe, rst_n}, 2'h3);
        cyc(4 * TICK_DIV); chk({lin_oe, rst_n}, 2'h0);
        @(posedge i_clk); uv <= 1'h0; tx_bit <= 1'h1;
        cyc(10); chk({lin_oe, rst_n}, 2'h1);
        @(posedge i_clk); trip <= 1'h1; rel <= 1'h0;
        wait_mode(LPMFC_OFF, 20);
        @(posedge i_clk); trip <= 1'h0; rel <= 1'h1;
        wait_mode(LPMFC_STANDBY, 20);
        @(posedge i_clk); poff <= 1'h1; pon <= 1'h0;
        wait_mode(LPMFC_OFF, 20);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge i_clk);
        i_rst <= 1'h0;
        s_power();
        s_normal();
        s_timeout();
        s_standby();
        s_sleep(1'h0);
        s_wake();
        s_sleep(1'h1);
        @(posedge i_clk); cmd <= 2'h1;
        wait_mode(LPMFC_NORMAL, 20);
        s_uv_temp();
        summarize();
    end
endmodule
